// >>> scs_defs.svh
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH
// ****************************************************************
// register byte addresses
// ****************************************************************
`define SCS_PIN_CTRL_ADDR   8'h00
`define SCS_GEN_TWO_ADDR    8'h04
`define SCS_RECV_MC_ADDR    8'h08
`define SCS_XMIT_MC_ADDR    8'h0C
`define SCS_SER_CTRL_ADDR   8'h10
`define SCS_STATUS_ADDR     8'h14
`define SCS_TX_DATA_ADDR    8'h18
`define SCS_RX_DATA_ADDR    8'h1C
`define SCS_RECV_EN_BASE    8'h40
`define SCS_XMIT_EN_BASE    8'h60
// ****************************************************************
// field positions and reset values
// ****************************************************************
`define SCS_ENH_CLK_BIT     7
`define SCS_RECV_DIR_BIT    8
`define SCS_XMIT_DIR_BIT    9
`define SCS_GEN_MODE_BIT    13
`define SCS_WIDE_BIT        9
`define SCS_SC_MC_BIT       0
`define SCS_SC_STOP_BIT     1
`define SCS_SC_LEN_LSB      4
`define SCS_REG_RESET       16'h0000
`define SCS_NARROW_CHANS    7'h20
`define SCS_LAST_CHAN       7'h7F
`define SCS_RESP_OKAY       2'h0
`define SCS_RESP_SLVERR     2'h2
`endif

// >>> scs_pkg.sv
package scs_pkg;
  typedef enum logic [1:0]
  {
    SCS_WAIT  = 2'b01,
    SCS_SHIFT = 2'b10
  } scs_link_state_type;

  // configuration that crosses into the link domain as quasi-static levels
  typedef struct packed
  {
    logic [127:0] recv_en;
    logic [127:0] xmit_en;
    logic         wide;
    logic         multichan;
    logic         clock_stop;
    logic [2:0]   len_code;
  } scs_link_cfg_type;
endpackage

// >>> scs_serial_port.sv
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "scs_defs.svh"
// Overview of operation
// RQ1: generator source code is the pair enhanced_clock_mode, generator_clock_mode.
// RQ2: a bit clock pin chosen as generator input has its driver off.
// RQ3: receive pin as source, both directions out: only transmit pin drives.
// RQ4: transmit and receive channel selection are independent per frame.
// RQ5: up to 128 channels of one stream can be enabled individually.
// RQ6: both wide bits zero gives partitions A and B, 16 channels each.
// RQ7: after reset the port is in 32-channel mode.
// RQ8: both wide bits one enables 128 channels through partitions A to H.
// RQ9: each partition covers 16 consecutive channels, H is 112 to 127.
// RQ10: receive enable bit n set enables channel n; registers reset to 0.
// RQ11: transmit enable bit n set enables transmit in channel n.
// RQ12: clock stop mode uses single-phase frames with one word each.
// RQ13: word length selectable as 8, 12, 16, 20, 24 or 32 bits.
// RQ14: in clock stop mode transmitter and receiver share one role.
// RQ15: logic is static and works at any low serial clock rate.
// RQ16: partner keeps rate within 9 MBps multichannel, 38 MBps otherwise.
// RQ17: port keeps running while the processor core is halted.
// RQ18: enhanced mode is pin control bit 7, generator mode bit 13.
// RQ19: channel k uses enable bit k mod 16 of partition k div 16.
module scs_serial_port
(
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic        link_clk_in,
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  input  wire logic        recv_bit_clock_pin_in,
  output logic             recv_bit_clock_pin_out,
  output logic             recv_bit_clock_pin_oe_out,
  input  wire logic        xmit_bit_clock_pin_in,
  output logic             xmit_bit_clock_pin_out,
  output logic             xmit_bit_clock_pin_oe_out,
  output logic [1:0]       gen_source_out,
  input  wire logic        frame_sync_in,
  input  wire logic        data_in,
  output logic             data_out,
  output logic             data_oe_out
);
  // ****************************************************************
  // register file
  // ****************************************************************
  logic [15:0]  pin_control_register;
  logic [15:0]  generator_register_two;
  logic [15:0]  recv_multichannel_ctrl;
  logic [15:0]  xmit_multichannel_ctrl;
  logic [15:0]  serial_ctrl;
  logic [15:0]  recv_channel_enable [8];
  logic [15:0]  xmit_channel_enable [8];
  logic [31:0]  tx_word;
  logic [31:0]  rx_word;
  logic         rx_full;
  logic         tx_empty;
  logic         aw_hold;
  logic         w_hold;
  logic [7:0]   aw_addr;
  logic [31:0]  w_data;
  logic [3:0]   w_strb;
  logic         wr_do;
  logic         rd_do;
  logic         rd_rx;
  logic [31:0]  next_rdata;
  logic         next_rok;
  logic         enhanced_clock_mode;
  logic         generator_clock_mode;
  logic         recv_clock_direction;
  logic         xmit_clock_direction;
  logic         clock_stop_mode;
  logic         wide_mode;
  logic         gen_clk;
  logic         rx_tgl_s1;
  logic         rx_tgl_s2;
  logic         rx_tgl_s3;
  logic         ack_s1;
  logic         ack_s2;
  logic         ack_s3;
  logic         tx_req;
  logic         rx_event;
  logic         tx_event;
  scs_pkg::scs_link_cfg_type cfg;

  assign enhanced_clock_mode  = pin_control_register[`SCS_ENH_CLK_BIT]; // RQ18
  assign generator_clock_mode = generator_register_two[`SCS_GEN_MODE_BIT]; // RQ18
  assign clock_stop_mode      = serial_ctrl[`SCS_SC_STOP_BIT];
  assign recv_clock_direction = pin_control_register[`SCS_RECV_DIR_BIT];
  // one role for both ends while the clock is stopped between words
  assign xmit_clock_direction = clock_stop_mode ? recv_clock_direction // RQ14
                                                : pin_control_register[`SCS_XMIT_DIR_BIT];
  // mixed wide bits fall back to the 32-channel partitions
  assign wide_mode = recv_multichannel_ctrl[`SCS_WIDE_BIT] // RQ6 RQ8
                     & xmit_multichannel_ctrl[`SCS_WIDE_BIT];

  assign s_axi_awready_out = !aw_hold && !s_axi_bvalid_out;
  assign s_axi_wready_out  = !w_hold && !s_axi_bvalid_out;
  assign s_axi_arready_out = !s_axi_rvalid_out;
  assign wr_do = aw_hold && w_hold;
  assign rd_do = s_axi_arvalid_in && s_axi_arready_out;
  assign rd_rx = rd_do && (s_axi_araddr_in == `SCS_RX_DATA_ADDR);

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr_in;
      end
      else if (wr_do)
        aw_hold <= 1'b0;
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end
      else if (wr_do)
        w_hold <= 1'b0;
    end
  end

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      pin_control_register   <= `SCS_REG_RESET;
      generator_register_two <= `SCS_REG_RESET;
      recv_multichannel_ctrl <= `SCS_REG_RESET; // RQ7
      xmit_multichannel_ctrl <= `SCS_REG_RESET; // RQ7
      serial_ctrl            <= `SCS_REG_RESET;
      for (int i = 0; i < 8; i++)
      begin
        recv_channel_enable[i] <= `SCS_REG_RESET; // RQ10
        xmit_channel_enable[i] <= `SCS_REG_RESET;
      end
    end
    else if (wr_do)
    begin
      case (aw_addr)
        `SCS_PIN_CTRL_ADDR: pin_control_register   <= merge(pin_control_register, w_data, w_strb);
        `SCS_GEN_TWO_ADDR:  generator_register_two <= merge(generator_register_two, w_data, w_strb);
        `SCS_RECV_MC_ADDR:  recv_multichannel_ctrl <= merge(recv_multichannel_ctrl, w_data, w_strb);
        `SCS_XMIT_MC_ADDR:  xmit_multichannel_ctrl <= merge(xmit_multichannel_ctrl, w_data, w_strb);
        `SCS_SER_CTRL_ADDR: serial_ctrl            <= merge(serial_ctrl, w_data, w_strb);
        default:
        begin
          for (int i = 0; i < 8; i++)
          begin
            if (aw_addr == `SCS_RECV_EN_BASE + 8'(4 * i)) // RQ4 RQ10
              recv_channel_enable[i] <= merge(recv_channel_enable[i], w_data, w_strb);
            if (aw_addr == `SCS_XMIT_EN_BASE + 8'(4 * i)) // RQ4 RQ11
              xmit_channel_enable[i] <= merge(xmit_channel_enable[i], w_data, w_strb);
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // write response and read data
  // ****************************************************************
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= `SCS_RESP_OKAY;
    end
    else if (wr_do)
    begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= (aw_addr == `SCS_STATUS_ADDR || aw_addr == `SCS_RX_DATA_ADDR)
                          ? `SCS_RESP_SLVERR : `SCS_RESP_OKAY;
      if (aw_addr > `SCS_XMIT_EN_BASE + 8'h1C || aw_addr[1:0] != 2'h0
          || (aw_addr > `SCS_RX_DATA_ADDR && aw_addr < `SCS_RECV_EN_BASE))
        s_axi_bresp_out <= `SCS_RESP_SLVERR;
    end
    else if (s_axi_bready_in)
      s_axi_bvalid_out <= 1'b0;
  end

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_rok   = 1'b1;
    case (s_axi_araddr_in)
      `SCS_PIN_CTRL_ADDR: next_rdata = {16'h0000, pin_control_register};
      `SCS_GEN_TWO_ADDR:  next_rdata = {16'h0000, generator_register_two};
      `SCS_RECV_MC_ADDR:  next_rdata = {16'h0000, recv_multichannel_ctrl};
      `SCS_XMIT_MC_ADDR:  next_rdata = {16'h0000, xmit_multichannel_ctrl};
      `SCS_SER_CTRL_ADDR: next_rdata = {16'h0000, serial_ctrl};
      `SCS_STATUS_ADDR:   next_rdata = {27'h000_0000, wide_mode, gen_source_out, rx_full,
                                        tx_empty};
      `SCS_TX_DATA_ADDR:  next_rdata = tx_word;
      `SCS_RX_DATA_ADDR:  next_rdata = rx_word;
      default:
      begin
        next_rok = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
          if (s_axi_araddr_in == `SCS_RECV_EN_BASE + 8'(4 * i))
          begin
            next_rdata = {16'h0000, recv_channel_enable[i]};
            next_rok   = 1'b1;
          end
          if (s_axi_araddr_in == `SCS_XMIT_EN_BASE + 8'(4 * i))
          begin
            next_rdata = {16'h0000, xmit_channel_enable[i]};
            next_rok   = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h0000_0000;
      s_axi_rresp_out  <= `SCS_RESP_OKAY;
    end
    else if (rd_do)
    begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out  <= next_rdata;
      s_axi_rresp_out  <= next_rok ? `SCS_RESP_OKAY : `SCS_RESP_SLVERR;
    end
    else if (s_axi_rready_in)
      s_axi_rvalid_out <= 1'b0;
  end

  // ****************************************************************
  // generator clock and pin drivers
  // ****************************************************************
  // no halt input exists, so a stopped core never freezes the port
  always_ff @(posedge clk_in) // RQ17
  begin
    if (!resetn_in)
    begin
      gen_clk        <= 1'b0;
      gen_source_out <= 2'h0;
    end
    else
    begin
      gen_clk        <= !gen_clk;
      gen_source_out <= {enhanced_clock_mode, generator_clock_mode}; // RQ1
    end
  end

  assign recv_bit_clock_pin_out    = gen_clk;
  assign xmit_bit_clock_pin_out    = gen_clk;
  assign recv_bit_clock_pin_oe_out = recv_clock_direction && (gen_source_out != 2'h2); // RQ2 RQ3
  assign xmit_bit_clock_pin_oe_out = xmit_clock_direction && (gen_source_out != 2'h3); // RQ2

  // ****************************************************************
  // data words crossing between domains
  // ****************************************************************
  logic rx_tgl;
  logic tx_ack;
  logic [31:0] rx_word_link;

  assign rx_event = rx_tgl_s2 ^ rx_tgl_s3;
  assign tx_event = ack_s2 ^ ack_s3;

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      {rx_tgl_s1, rx_tgl_s2, rx_tgl_s3} <= 3'h0;
      {ack_s1, ack_s2, ack_s3} <= 3'h0;
    end
    else
    begin
      {rx_tgl_s1, rx_tgl_s2, rx_tgl_s3} <= {rx_tgl, rx_tgl_s1, rx_tgl_s2};
      {ack_s1, ack_s2, ack_s3} <= {tx_ack, ack_s1, ack_s2};
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      rx_word  <= 32'h0000_0000;
      rx_full  <= 1'b0;
      tx_word  <= 32'h0000_0000;
      tx_empty <= 1'b1;
      tx_req   <= 1'b0;
    end
    else
    begin
      // a new word beats a read that clears the flag in the same cycle
      if (rx_event)
      begin
        rx_word <= rx_word_link;
        rx_full <= 1'b1;
      end
      else if (rd_rx)
        rx_full <= 1'b0;
      if (wr_do && aw_addr == `SCS_TX_DATA_ADDR && tx_empty)
      begin
        tx_word  <= w_data;
        tx_empty <= 1'b0;
        tx_req   <= !tx_req;
      end
      else if (tx_event)
        tx_empty <= 1'b1;
    end
  end

  always_comb
  begin
    cfg.recv_en    = {recv_channel_enable[7], recv_channel_enable[6], recv_channel_enable[5],
                      recv_channel_enable[4], recv_channel_enable[3], recv_channel_enable[2],
                      recv_channel_enable[1], recv_channel_enable[0]}; // RQ9
    cfg.xmit_en    = {xmit_channel_enable[7], xmit_channel_enable[6], xmit_channel_enable[5],
                      xmit_channel_enable[4], xmit_channel_enable[3], xmit_channel_enable[2],
                      xmit_channel_enable[1], xmit_channel_enable[0]}; // RQ9
    cfg.wide       = wide_mode;
    cfg.multichan  = serial_ctrl[`SCS_SC_MC_BIT];
    cfg.clock_stop = clock_stop_mode;
    cfg.len_code   = serial_ctrl[`SCS_SC_LEN_LSB +: 3];
  end

  // ****************************************************************
  // link domain
  // ****************************************************************
  // level synchronisers; software changes the setup only while idle
  scs_pkg::scs_link_cfg_type cfg_s1;
  scs_pkg::scs_link_cfg_type lcfg;
  logic        lrst_s1;
  logic        lrst_n;
  logic        treq_s1;
  logic        treq_s2;
  logic        treq_s3;
  logic [31:0] tx_next;
  logic [31:0] rx_sh;
  logic [31:0] tx_sh;
  logic [5:0]  bit_cnt;
  logic [5:0]  word_len;
  logic [6:0]  chan;
  logic        word_done;
  logic        last_chan;
  logic        rx_chan_en;
  logic        tx_chan_en;
  scs_pkg::scs_link_state_type state;

  always_ff @(posedge link_clk_in)
  begin
    lrst_s1 <= resetn_in;
    lrst_n  <= lrst_s1;
    cfg_s1  <= cfg;
    lcfg    <= cfg_s1;
  end

  always_comb
  begin
    case (lcfg.len_code) // RQ13
      3'h0:    word_len = 6'd8;
      3'h1:    word_len = 6'd12;
      3'h2:    word_len = 6'd16;
      3'h3:    word_len = 6'd20;
      3'h4:    word_len = 6'd24;
      default: word_len = 6'd32;
    endcase
  end

  // single-word frames run without channel selection
  assign rx_chan_en = !lcfg.multichan || lcfg.clock_stop // RQ12 RQ19
                      || (lcfg.recv_en[chan] && (lcfg.wide || chan < `SCS_NARROW_CHANS)); // RQ5
  assign tx_chan_en = !lcfg.multichan || lcfg.clock_stop // RQ19
                      || (lcfg.xmit_en[chan] && (lcfg.wide || chan < `SCS_NARROW_CHANS)); // RQ4
  assign word_done = (state == scs_pkg::SCS_SHIFT) && (bit_cnt == word_len - 6'd1);
  assign last_chan = lcfg.clock_stop || !lcfg.multichan // RQ12
                     || chan == (lcfg.wide ? `SCS_LAST_CHAN : `SCS_NARROW_CHANS - 7'd1);
  assign data_out    = tx_sh[31];
  assign data_oe_out = (state == scs_pkg::SCS_SHIFT) && tx_chan_en; // RQ11

  // every step waits for a link edge, so any slow clock is fine
  always_ff @(posedge link_clk_in) // RQ15
  begin
    if (!lrst_n)
    begin
      state        <= scs_pkg::SCS_WAIT;
      bit_cnt      <= 6'd0;
      chan         <= 7'd0;
      rx_sh        <= 32'h0000_0000;
      tx_sh        <= 32'h0000_0000;
      rx_tgl       <= 1'b0;
      rx_word_link <= 32'h0000_0000;
    end
    else
    begin
      rx_sh   <= {rx_sh[30:0], data_in};
      tx_sh   <= {tx_sh[30:0], 1'b0};
      bit_cnt <= bit_cnt + 6'd1;
      case (state)
        scs_pkg::SCS_WAIT:
        begin
          bit_cnt <= 6'd0;
        end
        scs_pkg::SCS_SHIFT:
        begin
          if (word_done)
          begin
            bit_cnt <= 6'd0;
            chan    <= chan + 7'd1;
            tx_sh   <= tx_next << (6'd32 - word_len);
            if (rx_chan_en) // RQ10 RQ19
            begin
              rx_word_link <= {rx_sh[30:0], data_in} & (32'hFFFF_FFFF >> (6'd32 - word_len));
              rx_tgl       <= !rx_tgl;
            end
            if (last_chan)
              state <= scs_pkg::SCS_WAIT; // RQ12
          end
        end
        default:
          state <= scs_pkg::SCS_WAIT;
      endcase
      if (frame_sync_in)
      begin
        state   <= scs_pkg::SCS_SHIFT;
        bit_cnt <= 6'd0;
        chan    <= 7'd0;
        tx_sh   <= tx_next << (6'd32 - word_len);
      end
    end
  end

  always_ff @(posedge link_clk_in)
  begin
    if (!lrst_n)
    begin
      {treq_s1, treq_s2, treq_s3} <= 3'h0;
      tx_next <= 32'h0000_0000;
      tx_ack  <= 1'b0;
    end
    else
    begin
      {treq_s1, treq_s2, treq_s3} <= {tx_req, treq_s1, treq_s2};
      if (treq_s2 ^ treq_s3)
      begin
        tx_next <= tx_word;
        tx_ack  <= !tx_ack;
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_write_pin(logic [7:0] a);
    wr_do && aw_addr == a;
  endsequence
  property p_src_follows;
    @(posedge clk_in) disable iff (!resetn_in)
      s_write_pin(`SCS_GEN_TWO_ADDR) ##0 (w_strb[1] && w_data[13])
      |=> ##1 gen_source_out[0];
  endproperty
  a_src_follows: assert property (p_src_follows) else $error("source bit not taken"); // RQ1
  property p_recv_pin_off;
    @(posedge clk_in) disable iff (!resetn_in)
      gen_source_out == 2'h2 |-> !recv_bit_clock_pin_oe_out;
  endproperty
  a_recv_pin_off: assert property (p_recv_pin_off) else $error("receive pin driven"); // RQ2
  property p_xmit_pin_off;
    @(posedge clk_in) disable iff (!resetn_in)
      gen_source_out == 2'h3 |-> !xmit_bit_clock_pin_oe_out;
  endproperty
  a_xmit_pin_off: assert property (p_xmit_pin_off) else $error("transmit pin driven"); // RQ2
  property p_xmit_drives;
    @(posedge clk_in) disable iff (!resetn_in)
      gen_source_out == 2'h2 && pin_control_register[9:8] == 2'h3
      |-> xmit_bit_clock_pin_oe_out && !recv_bit_clock_pin_oe_out;
  endproperty
  a_xmit_drives: assert property (p_xmit_drives) else $error("wrong clock driver"); // RQ3
  property p_narrow_reset;
    @(posedge clk_in) !resetn_in |=> !wide_mode && recv_channel_enable[7] == 16'h0000;
  endproperty
  a_narrow_reset: assert property (p_narrow_reset) else $error("reset mode wrong"); // RQ7
  property p_write_answer;
    @(posedge clk_in) disable iff (!resetn_in)
      wr_do |=> s_axi_bvalid_out && !aw_hold && !w_hold;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("no write response");
  property p_rx_set_wins;
    @(posedge clk_in) disable iff (!resetn_in)
      rx_event && rd_rx |=> rx_full;
  endproperty
  a_rx_set_wins: assert property (p_rx_set_wins) else $error("rx word lost"); // RQ10
  property p_chan_gate;
    @(posedge link_clk_in) disable iff (!lrst_n)
      word_done && !rx_chan_en |=> $stable(rx_tgl);
  endproperty
  a_chan_gate: assert property (p_chan_gate) else $error("disabled channel taken"); // RQ19
  property p_stop_one_word;
    @(posedge link_clk_in) disable iff (!lrst_n)
      word_done && lcfg.clock_stop && !frame_sync_in |=> state == scs_pkg::SCS_WAIT;
  endproperty
  a_stop_one_word: assert property (p_stop_one_word) else $error("clock stop frame long"); // RQ12
endmodule

// >>> scs_link_partner.sv
`timescale 1ns/1ps
module scs_link_partner
(
  input  wire logic run_in,
  input  wire logic sdo_in,
  input  wire logic sdo_oe_in,
  output logic      link_clk_out,
  output logic      frame_sync_out,
  output logic      data_out
);
  logic [31:0] got;
  logic        pause;
  // clock stands low between frames and during bit gaps
  initial
  begin
    link_clk_out = 1'b0;
    frame_sync_out = 1'b0;
    data_out = 1'b0;
    pause = 1'b0;
    forever #3 link_clk_out = run_in & ~link_clk_out & ~pause;
  end
  // long streams repeat the word every 32 bits; gap stretches each bit to hold the rate down
  task automatic send(input logic [31:0] w, input int n, input int gap);
    @(negedge link_clk_out) frame_sync_out = 1'b1;
    for (int i = n - 1; i >= 0; i--)
    begin
      @(negedge link_clk_out) frame_sync_out = 1'b0;
      if (sdo_oe_in)
        got = {got[30:0], sdo_in};
      data_out = w[i % 32];
      pause = 1'b1;
      #(gap) pause = 1'b0;
    end
    // released line: never leave the last bit standing
    @(negedge link_clk_out) data_out = ~data_out;
  endtask
endmodule

// >>> scs_serial_port_tb.sv
`timescale 1ns/1ps
`include "scs_defs.svh"
module scs_serial_port_tb;
  logic        clk_in, resetn_in, link_clk_in, frame_sync_in, data_in, run;
  logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, w;
  logic [3:0]  s_axi_wstrb_in;
  logic        s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in;
  logic        s_axi_rready_in, s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  logic        s_axi_arready_out, s_axi_rvalid_out, data_out, data_oe_out;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, gen_source_out;
  logic        recv_bit_clock_pin_in, recv_bit_clock_pin_out, recv_bit_clock_pin_oe_out;
  logic        xmit_bit_clock_pin_in, xmit_bit_clock_pin_out, xmit_bit_clock_pin_oe_out;
  logic [31:0] exp_q[$];
  logic [31:0] v[16];
  int          lens[6] = '{8, 12, 16, 20, 24, 32};
  int          fails, checks;
  // undriven pins idle high
  assign recv_bit_clock_pin_in = recv_bit_clock_pin_oe_out ? recv_bit_clock_pin_out : 1'b1;
  assign xmit_bit_clock_pin_in = xmit_bit_clock_pin_oe_out ? xmit_bit_clock_pin_out : 1'b1;
  scs_link_partner far (.run_in(run), .link_clk_out(link_clk_in),
    .sdo_in(data_out), .sdo_oe_in(data_oe_out),
    .frame_sync_out(frame_sync_in), .data_out(data_in));
  scs_serial_port uut (.*);
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    if (fails == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 40)
    begin
      fails++;
      test_done();
    end
  endtask
  // ****************************************************************
  // bus master: responses are checked by the monitor below
  // ****************************************************************
  always @(negedge clk_in)
  begin
    if (s_axi_bvalid_out && s_axi_bready_in)
      chk("bresp", {30'h0, s_axi_bresp_out}, exp_q.pop_front());
    if (s_axi_rvalid_out && s_axi_rready_in)
      chk("rdata", s_axi_rdata_out, exp_q.pop_front());
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
    logic ta, tw, tv;
    int   n;
    exp_q.push_back({30'h0, rsp});
    @(posedge clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    n = 0;
    do
    begin
      @(negedge clk_in);
      ta = s_axi_awready_out;
      tw = s_axi_wready_out;
      tv = s_axi_bvalid_out;
      @(posedge clk_in);
      if (ta) s_axi_awvalid_in <= 1'b0;
      if (tw) s_axi_wvalid_in <= 1'b0;
      n++;
    end while (!tv && n < 40);
    s_axi_bready_in <= 1'b0;
    tmo(n);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic ta, tv;
    int   n;
    exp_q.push_back(e);
    @(posedge clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    n = 0;
    do
    begin
      @(negedge clk_in);
      ta = s_axi_arready_out;
      tv = s_axi_rvalid_out;
      @(posedge clk_in);
      if (ta) s_axi_arvalid_in <= 1'b0;
      n++;
    end while (!tv && n < 40);
    s_axi_rready_in <= 1'b0;
    tmo(n);
  endtask
  task automatic frame(input logic [31:0] d, input int n);
    run = 1'b1;
    // bit gaps: about 8.8 Mbit/s for long streams, 37 Mbit/s for single words
    far.send(d, n, n > 32 ? 110 : 23);
    run = 1'b0;
    repeat (10) @(posedge clk_in);
  endtask
  initial
  begin
    fails = 0;
    checks = 0;
    resetn_in = 1'b0;
    run = 1'b1;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in} = '0;
    {s_axi_rready_in, s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
    s_axi_wstrb_in = 4'h3;
    w = $urandom(42369);
    repeat (6) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(negedge clk_in);
    chk("src", {30'h0, gen_source_out}, 32'h0000_0000);
    run = 1'b0;
    rd(`SCS_RECV_MC_ADDR, 32'h0000_0000);
    rd(`SCS_XMIT_MC_ADDR, 32'h0000_0000);
    for (int i = 0; i < 16; i++)
      rd(`SCS_RECV_EN_BASE + 8'(4 * i), 32'h0000_0000);
    for (int i = 0; i < 16; i++)
    begin
      v[i] = {16'h0000, 16'($urandom)};
      wr(`SCS_RECV_EN_BASE + 8'(4 * i), v[i], `SCS_RESP_OKAY);
    end
    for (int i = 0; i < 16; i++)
      rd(`SCS_RECV_EN_BASE + 8'(4 * i), v[i]);
    rd(8'h30, 32'h0000_0000);
    wr(`SCS_STATUS_ADDR, 32'h0000_FFFF, `SCS_RESP_SLVERR);
    for (int c = 0; c < 4; c++)
    begin
      wr(`SCS_PIN_CTRL_ADDR, 32'h0000_0300 | (32'(c >> 1) << `SCS_ENH_CLK_BIT), 2'h0);
      wr(`SCS_GEN_TWO_ADDR, 32'(c & 1) << `SCS_GEN_MODE_BIT, `SCS_RESP_OKAY);
      repeat (3) @(posedge clk_in);
      @(negedge clk_in);
      chk("src", {30'h0, gen_source_out}, 32'(c));
      chk("r_oe", {31'h0, recv_bit_clock_pin_oe_out}, {31'h0, c != 2});
      chk("x_oe", {31'h0, xmit_bit_clock_pin_oe_out}, {31'h0, c != 3});
    end
    for (int c = 0; c < 6; c++)
    begin
      wr(`SCS_SER_CTRL_ADDR, 32'(c) << `SCS_SC_LEN_LSB, `SCS_RESP_OKAY);
      w = $urandom;
      frame(w, lens[c]);
      rd(`SCS_RX_DATA_ADDR, w & ~(32'hFFFF_FFFF << lens[c]));
    end
    // the first frame hands the word across, the second sends it
    wr(`SCS_TX_DATA_ADDR, w, `SCS_RESP_OKAY);
    frame(w, 32);
    frame(w, 32);
    chk("tx", far.got, w);
    rd(`SCS_STATUS_ADDR, 32'h0000_000F);
    wr(`SCS_RECV_MC_ADDR, 32'h0000_0200, `SCS_RESP_OKAY);
    wr(`SCS_XMIT_MC_ADDR, 32'h0000_0200, `SCS_RESP_OKAY);
    for (int i = 0; i < 8; i++)
      wr(`SCS_RECV_EN_BASE + 8'(4 * i), 32'(i == 7), `SCS_RESP_OKAY);
    wr(`SCS_SER_CTRL_ADDR, 32'h0000_0001, `SCS_RESP_OKAY);
    w = $urandom;
    // only receive channel 112 is enabled, it carries the top byte
    frame(w, 1024);
    rd(`SCS_RX_DATA_ADDR, {24'h0, w[31:24]});
    test_done();
  end
endmodule
